// File: src/jtf_pkg.sv
// Notes on behaviour
// R1 - the tap state machine steps only on test clock, steered by mode select
// R2 - each state connects the instruction register or one data register to serial out
// R3 - held instruction picks the data register and its surrounding behaviour
// R4 - identification, bypass and boundary-scan chains are selectable data registers
// R5 - a programming path made of data registers reaches non-volatile memories
// R6 - internal scan and breakpoint chains exist for on-chip debugging only
// R7 - far side shifts bits in on data input; device returns the register's bits out
// R8 - no test-reset pin; reset only by mode-select sequence or power-on reset
// R9 - with the enable fuse unprogrammed, pins are port pins and the tap is held reset
// R10 - fuse programmed and disable bit clear: port enabled, input pins pulled high
// R11 - serial out is undriven in every state except the two shifting states
// R12 - the far side pulls the serial out line up while it is undriven
// R13 - the enable fuse reads programmed by default, as shipped
// R14 - a debugger watches the reset pin to see external resets
// R15 - a debugger may pull reset low; reset line must be open collector only
// R16 - sixteen states; test-logic-reset is entered after power-on reset
// R17 - every shift register moves its least significant bit first
// R18 - while an instruction shifts in, the fixed capture value 0x01 shifts out
// R19 - mode select high for five test clocks always reaches test-logic-reset
// R20 - inputs sampled on rising test clock, serial out changes on falling edges
package jtf_pkg;

  // ----------------------------------------------------------------
  // register widths and fixed values
  // ----------------------------------------------------------------
  localparam int IR_WIDTH = 4;
  localparam int ID_WIDTH = 32;
  localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 4'h1;
  localparam logic BYPASS_CAPTURE = 1'b0;
  localparam logic FUSE_RESET_VALUE = 1'b1;

  // ----------------------------------------------------------------
  // instruction codes
  // ----------------------------------------------------------------
  localparam logic [IR_WIDTH-1:0] INS_EXTEST = 4'h0;
  localparam logic [IR_WIDTH-1:0] INS_IDCODE = 4'h1;
  localparam logic [IR_WIDTH-1:0] INS_SAMPLE = 4'h2;
  localparam logic [IR_WIDTH-1:0] INS_PROG = 4'h4;
  localparam logic [IR_WIDTH-1:0] INS_INT_SCAN = 4'h8;
  localparam logic [IR_WIDTH-1:0] INS_BRK_SCAN = 4'h9;
  localparam logic [IR_WIDTH-1:0] INS_BYPASS = 4'hf;
  localparam logic [IR_WIDTH-1:0] IR_RESET_VALUE = INS_IDCODE;

  // ----------------------------------------------------------------
  // external chain numbering
  // ----------------------------------------------------------------
  localparam int NUM_CHAINS = 4;
  localparam int CH_BOUNDARY = 0;
  localparam int CH_PROG = 1;
  localparam int CH_INT_SCAN = 2;
  localparam int CH_BRK_SCAN = 3;

  // ----------------------------------------------------------------
  // controller states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [15:0] {
    ST_TLR = 16'h0001,
    ST_RTI = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PAU_DR = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PAU_IR = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } jtf_state_t;

  // control strobes to the external chains
  typedef struct packed {
    logic [NUM_CHAINS-1:0] sel;
    logic capture;
    logic shift;
    logic update;
  } jtf_chain_ctl_t;

endpackage

// File: src/jtf_tap_fsm.sv
`timescale 1ns/10ps
module jtf_tap_fsm
  import jtf_pkg::*;
(
  // test clock domain
  input wire logic tck,
  input wire logic tapRst,
  // steering
  input wire logic tms,
  // state
  output jtf_state_t state,
  output jtf_state_t stateNext
);

  jtf_state_t state_reg;
  jtf_state_t state_next;

  // ----------------------------------------------------------------
  // next-state table
  // ----------------------------------------------------------------
  // five ones from any state walk into ST_TLR by construction
  always_comb begin // R19
    state_next = ST_TLR;
    unique case (state_reg)
      ST_TLR: state_next = tms ? ST_TLR : ST_RTI;
      ST_RTI: state_next = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: state_next = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_next = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: state_next = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_next = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: state_next = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: state_next = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_next = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: state_next = tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: state_next = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: state_next = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_next = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: state_next = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: state_next = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_next = tms ? ST_SEL_DR : ST_RTI;
      default: state_next = ST_TLR; // illegal code recovers to reset
    endcase
  end

  // state register: rising test clock only, reset lands in ST_TLR
  always_ff @(posedge tck or posedge tapRst) begin // R1 R16
    if (tapRst) begin
      state_reg <= ST_TLR;
    end else begin
      state_reg <= state_next;
    end
  end

  assign state = state_reg;
  assign stateNext = state_next;

endmodule // jtf_tap_fsm

// File: src/jtf_shift_reg.sv
`timescale 1ns/10ps
module jtf_shift_reg
  import jtf_pkg::*;
#(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] UPDATE_RESET = '0
)
(
  // test clock domain
  input wire logic tck,
  input wire logic tapRst,
  // control from the controller
  input wire logic clear,
  input wire logic capture,
  input wire logic shift,
  input wire logic update,
  // data
  input wire logic [WIDTH-1:0] captureValue,
  input wire logic serialIn,
  output logic serialOut,
  output logic [WIDTH-1:0] parallelOut
);

  logic [WIDTH-1:0] shift_reg;
  logic [WIDTH-1:0] hold_reg;

  if (WIDTH < 1) begin : g_check
    $error("jtf_shift_reg needs WIDTH of at least 1");
  end

  // ----------------------------------------------------------------
  // shift stage
  // ----------------------------------------------------------------
  // new bits enter at the top so the lowest bit leaves first
  always_ff @(posedge tck or posedge tapRst) begin // R17
    if (tapRst) begin
      shift_reg <= '0;
    end else if (capture) begin
      shift_reg <= captureValue;
    end else if (shift) begin
      if (WIDTH == 1) begin
        shift_reg <= serialIn;
      end else begin
        shift_reg <= {serialIn, shift_reg[WIDTH-1:1]};
      end
    end
  end

  // update stage: holds the value while new bits shift behind it
  always_ff @(posedge tck or posedge tapRst) begin
    if (tapRst) begin
      hold_reg <= UPDATE_RESET;
    end else if (clear) begin
      hold_reg <= UPDATE_RESET;
    end else if (update) begin
      hold_reg <= shift_reg;
    end
  end

  assign serialOut = shift_reg[0];
  assign parallelOut = hold_reg;

endmodule // jtf_shift_reg

// File: src/jtf_tap_front_end.sv
`timescale 1ns/10ps
module jtf_tap_front_end
  import jtf_pkg::*;
#(
  // identification value is arbitrary; bit 0 stays one as the test standard asks
  parameter logic [ID_WIDTH-1:0] ID_CODE = 32'h0000_0001
)
(
  // system clock and power-on reset
  input wire logic clock,
  input wire logic sys_rst,
  // fuse and disable bit, system domain
  input wire logic testPortEnableFuse,
  input wire logic testPortDisableBit,
  // pin control and status toward the port, system domain
  output logic pinPullupEn,
  output logic pinGpioMode,
  output logic tapActive,
  // test port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdoOut,
  output logic tdoOe_n,
  // external chains, test clock domain
  input wire logic [NUM_CHAINS-1:0] chainSerialOut,
  output jtf_chain_ctl_t chainCtl,
  output logic [IR_WIDTH-1:0] instruction
);

  if (ID_CODE[0] != 1'b1) begin : g_id_check
    $error("ID_CODE bit 0 must be one");
  end

  // ----------------------------------------------------------------
  // system domain: fuse shadow and enable decision
  // ----------------------------------------------------------------
  logic fuse_reg;
  logic enable_reg;
  logic enable_next;
  logic pinPullupEn_reg;
  logic pinGpioMode_reg;

  // fuse powers up as programmed and is sampled once reset is gone
  always_ff @(posedge clock or posedge sys_rst) begin // R13
    if (sys_rst) begin
      fuse_reg <= FUSE_RESET_VALUE;
    end else begin
      fuse_reg <= testPortEnableFuse;
    end
  end

  // port runs only with the fuse programmed and the disable bit clear
  assign enable_next = fuse_reg & ~testPortDisableBit; // R10

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      enable_reg <= 1'b0;
      pinPullupEn_reg <= 1'b0;
      pinGpioMode_reg <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      pinPullupEn_reg <= enable_next; // R10
      pinGpioMode_reg <= ~fuse_reg; // R9
    end
  end

  assign pinPullupEn = pinPullupEn_reg;
  assign pinGpioMode = pinGpioMode_reg;

  // ----------------------------------------------------------------
  // tap reset: power-on or disabled port, no dedicated reset pin
  // ----------------------------------------------------------------
  // assertion is immediate; release is timed to the test clock so the
  // controller never sees a partial edge. the test clock may stand still,
  // so release waits for the tester's first edges.
  logic tapRstRaw;
  logic rstSync1_reg;
  logic rstSync2_reg;
  logic tapRst;

  assign tapRstRaw = sys_rst | ~enable_reg; // R8 R9

  always_ff @(posedge tck or posedge tapRstRaw) begin
    if (tapRstRaw) begin
      rstSync1_reg <= 1'b1;
      rstSync2_reg <= 1'b1;
    end else begin
      rstSync1_reg <= 1'b0;
      rstSync2_reg <= rstSync1_reg;
    end
  end

  assign tapRst = rstSync2_reg;

  // ----------------------------------------------------------------
  // controller
  // ----------------------------------------------------------------
  jtf_state_t state;
  jtf_state_t stateNext;

  jtf_tap_fsm u_fsm (
    .tck(tck),
    .tapRst(tapRst),
    .tms(tms),
    .state(state),
    .stateNext(stateNext)
  );

  // state decode
  logic inTlr;
  logic inCapDr;
  logic inShDr;
  logic inUpdDr;
  logic inCapIr;
  logic inShIr;
  logic inUpdIr;
  logic nextCapDr;
  logic nextShDr;
  logic nextUpdDr;
  assign inTlr = (state == ST_TLR);
  assign inCapDr = (state == ST_CAP_DR);
  assign inShDr = (state == ST_SH_DR);
  assign inUpdDr = (state == ST_UPD_DR);
  assign inCapIr = (state == ST_CAP_IR);
  assign inShIr = (state == ST_SH_IR);
  assign inUpdIr = (state == ST_UPD_IR);
  assign nextCapDr = (stateNext == ST_CAP_DR);
  assign nextShDr = (stateNext == ST_SH_DR);
  assign nextUpdDr = (stateNext == ST_UPD_DR);

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  logic irSerialOut;
  logic [IR_WIDTH-1:0] irValue;

  // capture loads the fixed pattern that leaves while a new code enters
  jtf_shift_reg #(
    .WIDTH(IR_WIDTH),
    .UPDATE_RESET(IR_RESET_VALUE)
  ) u_ir (
    .tck(tck),
    .tapRst(tapRst),
    .clear(inTlr),
    .capture(inCapIr),
    .shift(inShIr),
    .update(inUpdIr),
    .captureValue(IR_CAPTURE), // R18
    .serialIn(tdi), // R7
    .serialOut(irSerialOut),
    .parallelOut(irValue)
  );

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  // unknown codes fall back to bypass so the chain length stays defined
  logic selId;
  logic selBoundary;
  logic selProg;
  logic selIntScan;
  logic selBrkScan;
  logic selBypass;
  logic [NUM_CHAINS-1:0] chainSel;
  assign selId = (irValue == INS_IDCODE); // R3
  assign selBoundary = (irValue == INS_EXTEST) | (irValue == INS_SAMPLE); // R3
  assign selProg = (irValue == INS_PROG); // R3
  assign selIntScan = (irValue == INS_INT_SCAN); // R3
  assign selBrkScan = (irValue == INS_BRK_SCAN); // R3
  assign selBypass = ~(selId | selBoundary | selProg | selIntScan | selBrkScan);
  assign chainSel[CH_BOUNDARY] = selBoundary; // R4
  assign chainSel[CH_PROG] = selProg; // R5
  assign chainSel[CH_INT_SCAN] = selIntScan; // R6
  assign chainSel[CH_BRK_SCAN] = selBrkScan; // R6

  // ----------------------------------------------------------------
  // identification and bypass registers
  // ----------------------------------------------------------------
  logic idSerialOut;
  logic bypass_reg;

  jtf_shift_reg #(
    .WIDTH(ID_WIDTH),
    .UPDATE_RESET('0)
  ) u_id (
    .tck(tck),
    .tapRst(tapRst),
    .clear(1'b0),
    .capture(inCapDr & selId),
    .shift(inShDr & selId),
    .update(1'b0),
    .captureValue(ID_CODE), // R4
    .serialIn(tdi),
    .serialOut(idSerialOut),
    .parallelOut()
  );

  // single-bit bypass captures zero and passes data one clock late
  always_ff @(posedge tck or posedge tapRst) begin // R4
    if (tapRst) begin
      bypass_reg <= 1'b0;
    end else if (inCapDr & selBypass) begin
      bypass_reg <= BYPASS_CAPTURE;
    end else if (inShDr & selBypass) begin
      bypass_reg <= tdi;
    end
  end

  // ----------------------------------------------------------------
  // external chain strobes
  // ----------------------------------------------------------------
  // strobes are registered from the next state so each is high exactly
  // during the matching state, straight from a flip-flop
  jtf_chain_ctl_t chainCtl_reg;
  jtf_chain_ctl_t chainCtl_next;
  logic [NUM_CHAINS-1:0] nextSel;

  // selection follows a new instruction only once it is updated
  assign nextSel = (stateNext == ST_TLR) ? '0 : chainSel;
  assign chainCtl_next.sel = nextSel; // R3
  assign chainCtl_next.capture = nextCapDr & (|nextSel);
  assign chainCtl_next.shift = nextShDr & (|nextSel); // R7
  assign chainCtl_next.update = nextUpdDr & (|nextSel);

  always_ff @(posedge tck or posedge tapRst) begin
    if (tapRst) begin
      chainCtl_reg <= '0;
    end else begin
      chainCtl_reg <= chainCtl_next;
    end
  end

  assign chainCtl = chainCtl_reg;
  assign instruction = irValue;

  // ----------------------------------------------------------------
  // serial output selection
  // ----------------------------------------------------------------
  logic drSerialOut;
  logic tdoNext;
  logic shifting;
  logic [NUM_CHAINS-1:0] chainPick;

  // only one chain is selected, so an or-reduce is a clean mux
  assign chainPick = chainSerialOut & chainSel;
  assign drSerialOut = (selId & idSerialOut) | (selBypass & bypass_reg) | (|chainPick); // R2
  assign tdoNext = inShIr ? irSerialOut : drSerialOut; // R2 R7
  assign shifting = inShIr | inShDr;

  // ----------------------------------------------------------------
  // output stage on the falling test clock
  // ----------------------------------------------------------------
  // changing on the falling edge gives the next device half a period of
  // setup before it samples on the rising edge
  logic tdoOut_reg;
  logic tdoOe_n_reg;

  always_ff @(negedge tck or posedge tapRst) begin // R20
    if (tapRst) begin
      tdoOut_reg <= 1'b1;
      tdoOe_n_reg <= 1'b1;
    end else begin
      tdoOut_reg <= tdoNext; // R7
      tdoOe_n_reg <= ~shifting; // R11
    end
  end

  assign tdoOut = tdoOut_reg;
  assign tdoOe_n = tdoOe_n_reg;

  // ----------------------------------------------------------------
  // activity status back to the system domain
  // ----------------------------------------------------------------
  // out of test-logic-reset counts as active; three stages, change taken
  // once the last two agree
  logic active_reg;
  logic actSync1_reg;
  logic actSync2_reg;
  logic actSync3_reg;
  logic tapActive_reg;

  always_ff @(posedge tck or posedge tapRst) begin
    if (tapRst) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= (stateNext != ST_TLR); // state entered, valid even if the test clock stops
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      actSync1_reg <= 1'b0;
      actSync2_reg <= 1'b0;
      actSync3_reg <= 1'b0;
    end else begin
      actSync1_reg <= active_reg;
      actSync2_reg <= actSync1_reg;
      actSync3_reg <= actSync2_reg;
    end
  end

  // a disabled port reads inactive at once, whatever the stale stages hold
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tapActive_reg <= 1'b0;
    end else if (~enable_reg) begin
      tapActive_reg <= 1'b0;
    end else if (actSync2_reg == actSync3_reg) begin
      tapActive_reg <= actSync3_reg;
    end
  end

  assign tapActive = tapActive_reg;

endmodule // jtf_tap_front_end

// File: bench/jtf_tap_front_end_properties.sv
`timescale 1ns/10ps
module jtf_tap_front_end_properties
  import jtf_pkg::*;
(
  // clocks and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic tck,
  // watched ports
  input wire logic testPortEnableFuse,
  input wire logic testPortDisableBit,
  input wire logic pinPullupEn,
  input wire logic pinGpioMode,
  input wire logic tapActive,
  input wire logic tms,
  input wire logic tdoOut,
  input wire logic tdoOe_n,
  input wire logic [NUM_CHAINS-1:0] chainSerialOut,
  input wire jtf_chain_ctl_t chainCtl,
  input wire logic [IR_WIDTH-1:0] instruction
);
  // ------------------------------------------------------------
  // test clock domain
  // ------------------------------------------------------------
  // values sampled at a rising edge reflect the falling edge before it
  property p_sel_onehot;
    @(posedge tck) disable iff (sys_rst) $onehot0(chainCtl.sel);
  endproperty
  a_sel_onehot: assert property (p_sel_onehot) else $error("chain select not one-hot");
  property p_strobe_sel;
    @(posedge tck) disable iff (sys_rst)
      (chainCtl.capture || chainCtl.shift || chainCtl.update) |-> $onehot(chainCtl.sel);
  endproperty
  a_strobe_sel: assert property (p_strobe_sel) else $error("strobe without a chain");
  property p_oe_shift;
    @(posedge tck) disable iff (sys_rst) chainCtl.shift |-> !tdoOe_n;
  endproperty
  a_oe_shift: assert property (p_oe_shift) else $error("serial out undriven in shift");
  property p_oe_idle;
    @(posedge tck) disable iff (sys_rst) (chainCtl.capture || chainCtl.update) |-> tdoOe_n;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("serial out driven off shift");
  property p_oe_exit;
    @(posedge tck) disable iff (sys_rst) $fell(chainCtl.shift) |-> tdoOe_n;
  endproperty
  a_oe_exit: assert property (p_oe_exit) else $error("serial out driven after shift");
  property p_tdo_chain;
    @(posedge tck) disable iff (sys_rst)
      chainCtl.shift |-> tdoOut == |(chainSerialOut & chainCtl.sel);
  endproperty
  a_tdo_chain: assert property (p_tdo_chain) else $error("serial out not from chain");
  property p_five;
    @(posedge tck) disable iff (sys_rst)
      tms [*6] |=> instruction == IR_RESET_VALUE && chainCtl == '0;
  endproperty
  a_five: assert property (p_five) else $error("mode select ones did not reset");
  // ------------------------------------------------------------
  // system clock domain
  // ------------------------------------------------------------
  property p_gpio;
    @(posedge clock) disable iff (sys_rst)
      !testPortEnableFuse [*3] |-> pinGpioMode && !pinPullupEn;
  endproperty
  a_gpio: assert property (p_gpio) else $error("pins not ordinary port pins");
  property p_pullup;
    @(posedge clock) disable iff (sys_rst)
      (testPortEnableFuse && !testPortDisableBit) [*3] |-> pinPullupEn && !pinGpioMode;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-ups not enabled");
  property p_disable;
    @(posedge clock) disable iff (sys_rst)
      testPortDisableBit [*5] |-> !tapActive && !pinPullupEn;
  endproperty
  a_disable: assert property (p_disable) else $error("port active while disabled");
endmodule // jtf_tap_front_end_properties

bind jtf_tap_front_end jtf_tap_front_end_properties i_props (.clock, .sys_rst, .tck,
  .testPortEnableFuse, .testPortDisableBit, .pinPullupEn, .pinGpioMode, .tapActive,
  .tms, .tdoOut, .tdoOe_n, .chainSerialOut, .chainCtl, .instruction);

// File: bench/jtf_tester_model.sv
`timescale 1ns/10ps
module jtf_tester_model (
  // test port toward the device
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdoOut,
  input wire logic tdoOe_n,
  // system reset line watched by the debugger
  input wire logic rstPin
);
  // releases of the reset line seen so far, so external resets are noticed
  int resetsSeen = 0;
  always @(negedge rstPin) begin
    resetsSeen++;
  end
  // line pulled up while undriven, so a floating bit reads one
  wire logic tdoLine = tdoOe_n ? 1'b1 : tdoOut;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one 64 ns period; tck stands still low between calls
  task automatic step(input logic m, input logic d, output logic seen);
    tms = m;
    tdi = d;
    #16;
    seen = tdoLine;
    tck = 1'b1;
    #32;
    tck = 1'b0;
    #16;
  endtask
endmodule // jtf_tester_model

// File: bench/test_jtf_tap_front_end.sv
`timescale 1ns/10ps
module test_jtf_tap_front_end;
  import jtf_pkg::*;
  // arbitrary identification value, bit 0 kept one
  localparam logic [ID_WIDTH-1:0] ID_VAL = 32'h5a3c_96e1;
  logic clock, sys_rst, fuse, disBit, pullEn, gpioMode, active;
  logic tck, tms, tdi, tdoOut, tdoOe_n;
  logic [NUM_CHAINS-1:0] chainOut;
  jtf_chain_ctl_t chainCtl;
  logic [IR_WIDTH-1:0] instruction;
  logic [31:0] d;
  int err_count, samples_checked, cycles;

  jtf_tap_front_end #(.ID_CODE(ID_VAL)) i_dut (.clock, .sys_rst,
    .testPortEnableFuse(fuse), .testPortDisableBit(disBit), .pinPullupEn(pullEn),
    .pinGpioMode(gpioMode), .tapActive(active), .tck, .tms, .tdi, .tdoOut, .tdoOe_n,
    .chainSerialOut(chainOut), .chainCtl, .instruction);
  jtf_tester_model i_tester (.tck, .tms, .tdi, .tdoOut, .tdoOe_n, .rstPin(sys_rst));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // a hang is cut short well beyond the few hundred cycles needed
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      $display("MISMATCH at %0t: run too long", $time);
      tally_and_finish;
    end
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // system-side inputs change just after a clock edge
  task automatic drive(input logic f, input logic b, input logic [3:0] ch);
    @(posedge clock);
    #1;
    fuse = f;
    disBit = b;
    chainOut = ch;
  endtask
  // tms sequence, bit 0 first
  task automatic walk(input logic [7:0] seq, input int n);
    logic s;
    for (int i = 0; i < n; i++) begin
      i_tester.step(seq[i], 1'b0, s);
    end
  endtask
  // shift n bits lsb first; the last one leaves with tms high
  task automatic shift(input logic [31:0] din, input int n, output logic [31:0] dout);
    logic s;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      i_tester.step(i == n - 1, din[i], s);
      dout[i] = s;
    end
  endtask
  task automatic load_ir(input logic [IR_WIDTH-1:0] code, output logic [31:0] cap);
    walk(8'h03, 4);
    shift({28'h0, code}, IR_WIDTH, cap);
    walk(8'h01, 2);
  endtask
  task automatic shift_dr(input logic [31:0] din, input int n, output logic [31:0] dout);
    walk(8'h01, 3);
    shift(din, n, dout);
    walk(8'h01, 2);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    repeat (4) @(posedge clock);
    check(pullEn, 1'b1, "pull-up after reset");
    check(gpioMode, 1'b0, "gpio after reset");
    check(active, 1'b0, "active after reset");
    check(tdoOe_n, 1'b1, "oe after reset");
    check(instruction, IR_RESET_VALUE, "ir after reset");
  endtask
  task automatic t_idcode;
    walk(8'h1f, 6);
    repeat (6) @(posedge clock);
    check(active, 1'b1, "active in idle");
    shift_dr(32'hffff_ffff, ID_WIDTH, d);
    check(d, ID_VAL, "id shift");
  endtask
  task automatic t_bypass;
    load_ir(INS_BYPASS, d);
    check(d[3:0], IR_CAPTURE, "ir capture");
    check(instruction, INS_BYPASS, "ir update");
    shift_dr(32'hb6, 8, d);
    check(d[7:0], 8'h6c, "bypass delay");
  endtask
  // each instruction must route exactly its own chain to serial out
  task automatic t_chains;
    logic [IR_WIDTH-1:0] codes [5] = '{INS_EXTEST, INS_SAMPLE, INS_PROG, INS_INT_SCAN,
                                       INS_BRK_SCAN};
    int chans [5] = '{CH_BOUNDARY, CH_BOUNDARY, CH_PROG, CH_INT_SCAN, CH_BRK_SCAN};
    for (int k = 0; k < 5; k++) begin
      drive(1'b1, 1'b0, 4'h1 << chans[k]);
      load_ir(codes[k], d);
      check(instruction, codes[k], "held instruction");
      walk(8'h01, 3);
      check(chainCtl.sel, 4'h1 << chans[k], "chain select");
      check(chainCtl.shift, 1'b1, "chain shift");
      shift(32'h0, 4, d);
      check(d[3:0], 4'hf, "chain data");
      walk(8'h01, 2);
    end
  endtask
  task automatic t_five;
    load_ir(INS_BYPASS, d);
    walk(8'h01, 3);
    walk(8'h3f, 6);
    check(instruction, IR_RESET_VALUE, "ir after ones");
    check(tdoOe_n, 1'b1, "oe after ones");
    repeat (6) @(posedge clock);
    check(active, 1'b0, "active after ones");
  endtask
  // disable bit, then an unprogrammed fuse, then back to normal
  task automatic t_disable;
    walk(8'h1f, 6);
    drive(1'b1, 1'b1, 4'h0);
    repeat (6) @(posedge clock);
    walk(8'h03, 4);
    check({active, pullEn, gpioMode, tdoOe_n}, 4'h1, "disabled port");
    drive(1'b0, 1'b0, 4'h0);
    repeat (6) @(posedge clock);
    walk(8'h03, 4);
    check({active, pullEn, gpioMode, tdoOe_n}, 4'h3, "fuse unprogrammed");
    check(instruction, IR_RESET_VALUE, "ir held reset");
    drive(1'b1, 1'b0, 4'h0);
    repeat (6) @(posedge clock);
    walk(8'h1f, 6);
    load_ir(INS_IDCODE, d);
    check(d[3:0], IR_CAPTURE, "ir capture re-enabled");
  endtask
  // a debugger driving the reset line high for two clocks resets the whole system mid-run
  task automatic t_sys_reset;
    load_ir(INS_BYPASS, d);
    @(posedge clock);
    #1;
    sys_rst = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    repeat (4) @(posedge clock);
    check(i_tester.resetsSeen, 2, "reset releases seen");
    check({active, instruction}, {1'b0, IR_RESET_VALUE}, "after system reset");
    walk(8'h1f, 6);
    repeat (6) @(posedge clock);
    check(active, 1'b1, "active after system reset");
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    fuse = FUSE_RESET_VALUE;
    disBit = 1'b0;
    chainOut = 4'h0;
    repeat (16) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    t_reset();
    t_idcode();
    t_bypass();
    t_chains();
    t_five();
    t_disable();
    t_sys_reset();
    tally_and_finish();
  end
endmodule // test_jtf_tap_front_end
